// ---- rtl/itd_pkg.sv ----
package itd_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ITD_ADDR_SCL_HIGH = 8'h18;
  localparam logic [7:0] ITD_ADDR_SCL_LOW = 8'h19;
  localparam logic [7:0] ITD_ADDR_DATAPATH = 8'h1a;
  localparam logic [7:0] ITD_ADDR_CRC_ERR = 8'h1b;
  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] ITD_SCL_RESET = 8'h7f;
  localparam logic [7:0] ITD_ZERO8 = 8'h00;
  localparam logic [7:0] ITD_CNT_MAX = 8'hff;
  localparam logic [7:0] ITD_ONE8 = 8'h01;
  localparam int ITD_BIT_AUX = 3;
  localparam int ITD_BIT_RSVD2 = 2;
  localparam int ITD_BIT_WIDE = 1;
  localparam int ITD_BIT_SURR = 0;
  localparam logic ITD_SURR_RESET = 1'b1;
  localparam logic ITD_WIDE_RESET = 1'b0;
  // ----------------------------------------------------------------
  // Timing: one count step is one system clock period
  // ----------------------------------------------------------------
  localparam int ITD_CLK_PERIOD_NS = 50;
  localparam int ITD_EXTRA_PERIODS = 5;
  localparam logic [8:0] ITD_EXTRA_M1 = 9'(ITD_EXTRA_PERIODS - 1);
  localparam logic [8:0] ITD_EXTRA_FULL = 9'(ITD_EXTRA_PERIODS);
  localparam logic [1:0] ITD_STRAP_SETTLE = 2'h3;
  // Master clock generator phases
  typedef enum logic [1:0] {ITD_MS_IDLE, ITD_MS_HIGH, ITD_MS_LOW} itd_mst_state_t;
endpackage

// ---- rtl/itd_phase_if.sv ----
`timescale 1ns/1ns
`default_nettype none
// Start and completion of one timed clock phase
interface itd_phase_if;
  logic start;
  logic [7:0] count;
  logic done;
  logic busy;
  modport ctl (output start, output count, input done, input busy);
  modport tmr (input start, input count, output done, output busy);
endinterface
`default_nettype wire

// ---- rtl/itd_phase_timer.sv ----
`timescale 1ns/1ns
`default_nettype none
module itd_phase_timer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Phase request
  itd_phase_if.tmr ph
);
  import itd_pkg::*;

  // ----------------------------------------------------------------
  // Down counter, phase lasts count plus the fixed extra periods
  // ----------------------------------------------------------------
  logic [8:0] cnt_q, cnt_d;
  logic busy_q, busy_d;

  assign ph.busy = busy_q;
  assign ph.done = busy_q && (cnt_q == 9'h000);

  // Restart allowed in the done cycle so back to back phases abut
  always_comb begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    if (ph.start) begin
      cnt_d = {1'b0, ph.count} + ITD_EXTRA_M1;
      busy_d = 1'b1;
    end else if (ph.done) begin
      busy_d = 1'b0;
    end else if (busy_q) begin
      cnt_d = cnt_q - 9'h001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 9'h000;
      busy_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [8:0] el_q;
  logic [8:0] exp_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      el_q <= 9'h000;
      exp_q <= 9'h000;
    end else if (ph.start) begin
      el_q <= 9'h001;
      exp_q <= {1'b0, ph.count} + ITD_EXTRA_FULL;
    end else begin
      el_q <= el_q + 9'h001;
    end
  end

  a_phase_exact_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ph.done |-> el_q == exp_q)
    else $error("phase length differs from count plus five");

  a_phase_min_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ph.start && !busy_q |=> !ph.done [*4])
    else $error("phase ended sooner than five periods");
endmodule
`default_nettype wire

// ---- rtl/itd_regs.sv ----
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Master SCL high phase sized by 8-bit register in count steps
// - Master SCL low phase sized by separate 8-bit register
// - Slave reuses low count as SDA setup before releasing SCL
// - Each phase lasts programmed count plus five extra periods; master SCL high lasts count plus ten, counting only once SCL is seen high
// - Both phase counts reset to 0x7F
// - Data path bit 3 is read-only auxiliary audio enable status
// - Auxiliary audio enable loaded from mode strap pin at power-up
// - Bit 1 selects 24-bit plus controls or 28-bit payload
// - Bit 0 selects surround audio, else basic channel configuration
// - Surround audio carried only by data-island transport
// - In repeater, in-band mode detection may override surround bit
// - Self-test CRC error counter is 8 bits, saturating at 255
// - Counter clears on new self-test run or software clear
module itd_regs (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register access port from the control interface
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Local master clock pin, open drain
  input wire logic scl_mst_i,
  output logic scl_mst_o,
  output logic scl_mst_oe,
  input wire logic mst_enable,
  // Slave data setup
  input wire logic slv_data_presented,
  output logic slv_scl_release,
  // Strap and auxiliary audio control
  input wire logic config_strap_pin_zero,
  input wire logic aux_cfg_wr,
  input wire logic aux_cfg_val,
  output logic aux_audio_en,
  // Data path controls
  input wire logic repeater_mode,
  input wire logic inband_override_en,
  input wire logic inband_surround_valid,
  input wire logic inband_surround,
  input wire logic [1:0] i2s_basic_cfg,
  output logic wide_payload_select,
  output logic surround_audio_en,
  output logic island_transport_force,
  output logic [1:0] i2s_chan_cfg,
  // Self-test back channel
  input wire logic selftest_active,
  input wire logic selftest_start,
  input wire logic selftest_count_clear,
  input wire logic bc_frame_done,
  input wire logic bc_crc_bad,
  output logic [7:0] selftest_crc_error_count
);
  import itd_pkg::*;
  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  logic [7:0] scl_high_q, scl_high_d;
  logic [7:0] scl_low_q, scl_low_d;
  logic wide_q, wide_d;
  logic surr_q, surr_d;
  always_comb begin
    scl_high_d = scl_high_q;
    scl_low_d = scl_low_q;
    wide_d = wide_q;
    surr_d = surr_q;
    if (reg_wr) begin
      unique case (reg_addr)
        ITD_ADDR_SCL_HIGH: scl_high_d = reg_wdata;
        ITD_ADDR_SCL_LOW: scl_low_d = reg_wdata;
        ITD_ADDR_DATAPATH: begin
          // Bit 3 is status only, writes to it are dropped
          wide_d = reg_wdata[ITD_BIT_WIDE];
          surr_d = reg_wdata[ITD_BIT_SURR];
        end
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_high_q <= ITD_SCL_RESET;
      scl_low_q <= ITD_SCL_RESET;
      wide_q <= ITD_WIDE_RESET;
      surr_q <= ITD_SURR_RESET;
    end else begin
      scl_high_q <= scl_high_d;
      scl_low_q <= scl_low_d;
      wide_q <= wide_d;
      surr_q <= surr_d;
    end
  end
  // ----------------------------------------------------------------
  // Pin synchronisers, strap capture and auxiliary audio status
  // ----------------------------------------------------------------
  logic [2:0] strap_sync_q; // Three stages per pin
  logic [2:0] scl_sync_q;
  // Filtered level: changes only once stages two and three agree
  logic scl_seen_q, scl_seen_d;
  assign scl_seen_d = (scl_sync_q[1] == scl_sync_q[2]) ? scl_sync_q[2] : scl_seen_q;
  logic [1:0] settle_q, settle_d;
  logic strap_taken_q, strap_taken_d;
  logic aux_q, aux_d;
  // Strap is caught after reset release, once the synchroniser has filled
  always_comb begin
    settle_d = settle_q;
    strap_taken_d = strap_taken_q;
    aux_d = aux_q;
    if (settle_q != ITD_STRAP_SETTLE) begin
      settle_d = settle_q + 2'h1;
    end else if (!strap_taken_q && (strap_sync_q[1] == strap_sync_q[2])) begin
      aux_d = strap_sync_q[2];
      strap_taken_d = 1'b1;
    end
    // Bridge configuration register may rewrite it later
    if (aux_cfg_wr && strap_taken_q) begin
      aux_d = aux_cfg_val;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      settle_q <= 2'h0;
      strap_taken_q <= 1'b0;
      aux_q <= 1'b0;
      scl_seen_q <= 1'b1;
      strap_sync_q <= 3'h0;
      scl_sync_q <= 3'h7;
    end else begin
      settle_q <= settle_d;
      strap_taken_q <= strap_taken_d;
      aux_q <= aux_d;
      scl_seen_q <= scl_seen_d;
      strap_sync_q <= {strap_sync_q[1:0], config_strap_pin_zero};
      scl_sync_q <= {scl_sync_q[1:0], scl_mst_i};
    end
  end
  assign aux_audio_en = aux_q;
  // ----------------------------------------------------------------
  // Data path outputs
  // ----------------------------------------------------------------
  logic surr_eff;
  // In-band detection wins in a repeater unless disabled
  assign surr_eff = (repeater_mode && inband_override_en && inband_surround_valid) ?
                    inband_surround : surr_q;
  assign surround_audio_en = surr_eff;
  assign island_transport_force = surr_eff;
  assign i2s_chan_cfg = surr_eff ? 2'h0 : i2s_basic_cfg;
  assign wide_payload_select = wide_q;
  // ----------------------------------------------------------------
  // Self-test CRC error counter
  // ----------------------------------------------------------------
  logic [7:0] crc_cnt_q, crc_cnt_d;
  logic crc_inc;
  logic crc_clr;
  assign crc_inc = selftest_active && bc_frame_done && bc_crc_bad;
  assign crc_clr = selftest_start || selftest_count_clear;
  // An error landing in the clear cycle is kept as the first count
  always_comb begin
    crc_cnt_d = crc_cnt_q;
    if (crc_clr) begin
      crc_cnt_d = crc_inc ? ITD_ONE8 : ITD_ZERO8;
    end else if (crc_inc && (crc_cnt_q != ITD_CNT_MAX)) begin
      crc_cnt_d = crc_cnt_q + ITD_ONE8;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      crc_cnt_q <= ITD_ZERO8;
    end else begin
      crc_cnt_q <= crc_cnt_d;
    end
  end
  assign selftest_crc_error_count = crc_cnt_q;
  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  logic [7:0] rdata_q, rdata_d;
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      unique case (reg_addr)
        ITD_ADDR_SCL_HIGH: rdata_d = scl_high_q;
        ITD_ADDR_SCL_LOW: rdata_d = scl_low_q;
        ITD_ADDR_DATAPATH: begin
          rdata_d = ITD_ZERO8;
          rdata_d[ITD_BIT_AUX] = aux_q;
          rdata_d[ITD_BIT_WIDE] = wide_q;
          rdata_d[ITD_BIT_SURR] = surr_q;
        end
        ITD_ADDR_CRC_ERR: rdata_d = crc_cnt_q;
        default: rdata_d = ITD_ZERO8;
      endcase
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= ITD_ZERO8;
    end else begin
      rdata_q <= rdata_d;
    end
  end
  assign reg_rdata = rdata_q;
  // ----------------------------------------------------------------
  // Master clock generator
  // ----------------------------------------------------------------
  itd_phase_if mst_ph ();
  itd_phase_if slv_ph ();
  itd_mst_state_t ms_q, ms_d;
  // High phase waits for the pin to read high, so a stretching slave holds it
  always_comb begin
    ms_d = ms_q;
    mst_ph.start = 1'b0;
    mst_ph.count = scl_low_q;
    unique case (ms_q)
      ITD_MS_IDLE: begin
        if (mst_enable) begin
          ms_d = ITD_MS_LOW;
          mst_ph.start = 1'b1;
        end
      end
      ITD_MS_LOW: begin
        if (mst_ph.done) begin
          ms_d = ITD_MS_HIGH;
        end
      end
      ITD_MS_HIGH: begin
        mst_ph.count = scl_high_q;
        if (!mst_ph.busy && scl_seen_q) begin
          mst_ph.start = 1'b1;
        end else if (mst_ph.done) begin
          ms_d = mst_enable ? ITD_MS_LOW : ITD_MS_IDLE;
          mst_ph.start = mst_enable;
          mst_ph.count = scl_low_q;
        end
      end
    endcase
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ms_q <= ITD_MS_IDLE;
    end else begin
      ms_q <= ms_d;
    end
  end
  assign scl_mst_o = 1'b0;
  assign scl_mst_oe = (ms_q == ITD_MS_LOW);
  itd_phase_timer u_mst_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ph(mst_ph.tmr)
  );
  // Slave data setup interval reuses the low count
  assign slv_ph.start = slv_data_presented && !slv_ph.busy;
  assign slv_ph.count = scl_low_q;
  assign slv_scl_release = slv_ph.done;
  itd_phase_timer u_slv_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ph(slv_ph.tmr)
  );
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_crc_saturate_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    crc_cnt_q == ITD_CNT_MAX && !crc_clr |=> crc_cnt_q == ITD_CNT_MAX)
    else $error("error counter left 255 without a clear");
  a_crc_single_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
    crc_inc && !crc_clr && crc_cnt_q != ITD_CNT_MAX |=> crc_cnt_q == $past(crc_cnt_q) + ITD_ONE8)
    else $error("error counter did not step by one");
  a_crc_idle_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !crc_inc && !crc_clr |=> $stable(crc_cnt_q))
    else $error("error counter moved without an error");
  a_crc_clear_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    crc_clr && !crc_inc |=> crc_cnt_q == ITD_ZERO8)
    else $error("error counter not cleared");
  a_surround_override: assert property (@(posedge clk_sys) disable iff (!rst_n)
    repeater_mode && inband_override_en && inband_surround_valid |->
    surround_audio_en == inband_surround)
    else $error("in-band detection did not override surround");
  a_island_forced: assert property (@(posedge clk_sys) disable iff (!rst_n)
    surround_audio_en |-> island_transport_force && i2s_chan_cfg == 2'h0)
    else $error("surround audio without island transport");
  a_aux_read_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_wr && reg_addr == ITD_ADDR_DATAPATH && !aux_cfg_wr && strap_taken_q |=> $stable(aux_q))
    else $error("auxiliary audio status changed by a data path write");
  a_scl_high_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_wr && reg_addr == ITD_ADDR_SCL_HIGH |=> scl_high_q == $past(reg_wdata))
    else $error("high count write lost");
  a_slv_uses_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
    slv_ph.start |-> slv_ph.count == scl_low_q)
    else $error("slave setup not sized by low count");
endmodule
`default_nettype wire

// ---- dv/itd_slave_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// Local bus slave that may stretch SCL after it falls
// ----------------------------------------------------------------
module itd_slave_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Bus line and stretch length, zero for a prompt slave
  input wire logic scl_line,
  input wire logic [7:0] stretch_cycles,
  output logic scl_slv_oe
);
  logic line_q;
  logic [7:0] cnt_q;
  // Hold the line low from its falling edge; pull-up restores it after
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      line_q <= 1'b1;
      cnt_q <= 8'h00;
    end else begin
      line_q <= scl_line;
      if (line_q && !scl_line) begin
        cnt_q <= stretch_cycles;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
  assign scl_slv_oe = (cnt_q != 8'h00);
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb;
  import itd_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n, reg_wr, reg_rd, mst_enable, slv_data_presented, config_strap_pin_zero;
  logic aux_cfg_wr, aux_cfg_val, repeater_mode, inband_override_en, inband_surround_valid;
  logic inband_surround, selftest_active, selftest_start, selftest_count_clear;
  logic bc_frame_done, bc_crc_bad, scl_mst_o, scl_mst_oe, slv_scl_release, aux_audio_en;
  logic wide_payload_select, surround_audio_en, island_transport_force, scl_slv_oe;
  logic [1:0] i2s_basic_cfg, i2s_chan_cfg;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, selftest_crc_error_count, stretch;
  int fail_count = 0;
  int checks_done = 0;
  int lo, hi, h0, ha, n;
  // Open-drain line with pull-up, low while either party pulls
  wire logic scl_line = ~(scl_mst_oe | scl_slv_oe);
  always #25 clk_sys = ~clk_sys;
  itd_regs i_itd_regs (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .scl_mst_i(scl_line), .scl_mst_o(scl_mst_o), .scl_mst_oe(scl_mst_oe), .mst_enable(mst_enable),
    .slv_data_presented(slv_data_presented), .slv_scl_release(slv_scl_release),
    .config_strap_pin_zero(config_strap_pin_zero), .aux_cfg_wr(aux_cfg_wr),
    .aux_cfg_val(aux_cfg_val), .aux_audio_en(aux_audio_en), .repeater_mode(repeater_mode),
    .inband_override_en(inband_override_en), .inband_surround_valid(inband_surround_valid),
    .inband_surround(inband_surround), .i2s_basic_cfg(i2s_basic_cfg),
    .wide_payload_select(wide_payload_select), .surround_audio_en(surround_audio_en),
    .island_transport_force(island_transport_force), .i2s_chan_cfg(i2s_chan_cfg),
    .selftest_active(selftest_active), .selftest_start(selftest_start),
    .selftest_count_clear(selftest_count_clear), .bc_frame_done(bc_frame_done),
    .bc_crc_bad(bc_crc_bad), .selftest_crc_error_count(selftest_crc_error_count));
  itd_slave_model i_itd_slave_model (.clk_sys(clk_sys), .rst_n(rst_n), .scl_line(scl_line),
    .stretch_cycles(stretch), .scl_slv_oe(scl_slv_oe));
  // ----------------------------------------------------------------
  // Access and compare tasks; all start and end at a falling edge
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    @(negedge clk_sys);
  endtask
  // Data is settled one falling edge after the strobe rises and is checked at the second
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    @(negedge clk_sys);
    chk(reg_rdata, exp);
  endtask
  task automatic frame(input logic bad);
    bc_frame_done = 1'b1;
    bc_crc_bad = bad;
    @(negedge clk_sys);
    bc_frame_done = 1'b0;
    bc_crc_bad = 1'b0;
    @(negedge clk_sys);
  endtask
  // Length of one driven-low phase and of the following released phase
  task automatic meas(output int l, output int h);
    mst_enable = 1'b1;
    l = 0;
    h = 0;
    @(negedge clk_sys);
    while (scl_mst_oe === 1'b1 && l < 300) begin
      l++;
      @(negedge clk_sys);
    end
    while (scl_mst_oe !== 1'b1 && h < 300) begin
      h++;
      @(negedge clk_sys);
    end
    mst_enable = 1'b0;
    repeat (80) @(negedge clk_sys);
  endtask
  task automatic stop_test;
    $display("fail_count=%0d checks_done=%0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Watchdog, far beyond the little over a thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    $display("CHECK FAILED t=%0t watchdog", $time);
    stop_test();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, reg_wr, reg_rd, mst_enable, slv_data_presented, aux_cfg_wr, aux_cfg_val} = '0;
    {repeater_mode, inband_override_en, inband_surround_valid, inband_surround} = '0;
    {selftest_active, selftest_start, selftest_count_clear, bc_frame_done, bc_crc_bad} = '0;
    config_strap_pin_zero = 1'b1;
    i2s_basic_cfg = 2'h2;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    stretch = 8'h00;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (8) @(negedge clk_sys);
    rd(ITD_ADDR_SCL_HIGH, 8'h7f);
    rd(ITD_ADDR_SCL_LOW, 8'h7f);
    rd(ITD_ADDR_CRC_ERR, 8'h00);
    rd(ITD_ADDR_DATAPATH, 8'h09);
    chk({7'h00, aux_audio_en}, 8'h01);
    wr(ITD_ADDR_DATAPATH, 8'hff);
    rd(ITD_ADDR_DATAPATH, 8'h0b);
    chk({7'h00, wide_payload_select}, 8'h01);
    wr(ITD_ADDR_DATAPATH, 8'h00);
    chk({7'h00, wide_payload_select}, 8'h00);
    chk({6'h00, i2s_chan_cfg}, 8'h02);
    chk({7'h00, island_transport_force}, 8'h00);
    wr(ITD_ADDR_DATAPATH, 8'h01);
    chk({7'h00, surround_audio_en}, 8'h01);
    chk({6'h00, i2s_chan_cfg}, 8'h00);
    chk({7'h00, island_transport_force}, 8'h01);
    // Outside a repeater the written choice stands
    {repeater_mode, inband_override_en, inband_surround_valid} = 3'h3;
    @(negedge clk_sys);
    chk({7'h00, surround_audio_en}, 8'h01);
    // In-band detection overrides the written surround choice
    {repeater_mode, inband_override_en, inband_surround_valid} = 3'h7;
    @(negedge clk_sys);
    chk({7'h00, surround_audio_en}, 8'h00);
    {repeater_mode, inband_override_en, inband_surround_valid} = 3'h0;
    aux_cfg_wr = 1'b1;
    @(negedge clk_sys);
    aux_cfg_wr = 1'b0;
    @(negedge clk_sys);
    rd(ITD_ADDR_DATAPATH, 8'h01);
    chk({7'h00, aux_audio_en}, 8'h00);
    wr(ITD_ADDR_CRC_ERR, 8'h55);
    rd(ITD_ADDR_CRC_ERR, 8'h00);
    rd(8'h7e, 8'h00);
    // Master clock phases, prompt and stretching slave
    wr(ITD_ADDR_SCL_LOW, 8'h03);
    wr(ITD_ADDR_SCL_HIGH, 8'h02);
    rd(ITD_ADDR_SCL_HIGH, 8'h02);
    meas(lo, h0);
    chk(8'(lo), 8'd8);
    chk({7'h00, scl_mst_o}, 8'h00);
    wr(ITD_ADDR_SCL_HIGH, 8'h04);
    meas(lo, hi);
    chk(8'(hi - h0), 8'd2);
    stretch = 8'd20;
    meas(lo, ha);
    stretch = 8'd26;
    meas(lo, hi);
    chk(8'(hi - ha), 8'd6);
    chk(8'(lo), 8'd8);
    stretch = 8'd0;
    // Slave data setup reuses the low count
    slv_data_presented = 1'b1;
    @(negedge clk_sys);
    slv_data_presented = 1'b0;
    n = 1;
    while (slv_scl_release !== 1'b1 && n < 300) begin
      n++;
      @(negedge clk_sys);
    end
    chk(8'(n), 8'd8);
    @(negedge clk_sys);
    chk({7'h00, slv_scl_release}, 8'h00);
    wr(ITD_ADDR_SCL_LOW, 8'h00);
    meas(lo, hi);
    chk(8'(lo), 8'd5);
    // Self-test error counter
    selftest_active = 1'b1;
    frame(1'b1);
    frame(1'b0);
    frame(1'b1);
    frame(1'b1);
    rd(ITD_ADDR_CRC_ERR, 8'h03);
    selftest_active = 1'b0;
    frame(1'b1);
    rd(ITD_ADDR_CRC_ERR, 8'h03);
    selftest_active = 1'b1;
    repeat (260) frame(1'b1);
    rd(ITD_ADDR_CRC_ERR, 8'hff);
    selftest_count_clear = 1'b1;
    @(negedge clk_sys);
    selftest_count_clear = 1'b0;
    rd(ITD_ADDR_CRC_ERR, 8'h00);
    frame(1'b1);
    selftest_start = 1'b1;
    @(negedge clk_sys);
    selftest_start = 1'b0;
    chk(selftest_crc_error_count, 8'h00);
    // Error and clear in one cycle: the error is kept as the first count
    {selftest_count_clear, bc_frame_done, bc_crc_bad} = 3'h7;
    @(negedge clk_sys);
    {selftest_count_clear, bc_frame_done, bc_crc_bad} = 3'h0;
    chk(selftest_crc_error_count, 8'h01);
    stop_test();
  end
endmodule
`default_nettype wire
